//--- design/vil_ctrl.sv
`timescale 1ns/1ns
// Operation
// RULE_01 - all vectors live in bytes 00h..FFh
// RULE_02 - reset entry 100h or boot-selected alternative
// RULE_03 - timer 0 sources on level 0
// RULE_04 - timer 1 sources on level 1, overflow auto-cleared
// RULE_05 - counter A alone on level 2
// RULE_06 - timer 2 sources on level 3
// RULE_07 - port 0 pins 4-7 share E8h, level 7
// RULE_08 - port 0 pins 0-3 level 6, own vectors
// RULE_09 - port 2 pins 4-7 share D8h, level 5
// RULE_10 - port 2 pins 0-3 level 4, own vectors
// RULE_11 - in-level priority value 0 is highest
// RULE_12 - lowest vector wins inside a level, fixed
// RULE_13 - free vector-area bytes usable, vectors protected
// RULE_14 - enable/disable instructions set/clear mode bit 0
// RULE_15 - enabled requests served in configured priority order
// RULE_16 - software must enable interrupts after reset
// RULE_17 - per-level mask register, read and write
// RULE_18 - priority register orders three level groups
// RULE_19 - read-only per-level pending register
// RULE_20 - mode register holds fast and external controls
// RULE_21 - grant disables interrupts, gives two vector bytes
// RULE_22 - reset clears mode bits 7, 1, 0
// RULE_23 - request needs pending, unmasked and global enable
module vil_ctrl (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [2:0] boot_sel,
  input wire logic [22:0] src_evt,
  input wire logic [22:0] sw_clr_pend,
  input wire logic global_enable_instr,
  input wire logic global_disable_instr,
  input wire logic sym_wr,
  input wire logic [7:0] sym_wdata,
  input wire logic mask_wr,
  input wire logic [7:0] mask_wdata,
  input wire logic prio_wr,
  input wire logic [7:0] prio_wdata,
  input wire logic int_ack,
  input wire logic prog_wr,
  input wire logic [15:0] prog_wr_addr,
  output logic [15:0] reset_vec_r,
  output logic int_req_r,
  output logic [2:0] req_level_r,
  output logic [7:0] vec_addr_r,
  output logic [7:0] vec_next_r,
  output logic [22:0] src_pend_r,
  output logic [7:0] level_pend_r,
  output logic [7:0] level_mask_reg,
  output logic [7:0] level_priority_reg,
  output logic [7:0] system_mode_reg,
  output logic vec_hit_r
);
  vil_pkg::vil_st_e st_r, st_nxt;
  logic [22:0] pend_nxt, grant_clr;
  logic [7:0] lvl_pend, lvl_act, mask_nxt, prio_nxt, sym_nxt, vec_nxt, vecn_nxt;
  logic [2:0] win_lvl, lvl_nxt;
  logic [4:0] win_src;
  logic any_act, any_src, req_nxt, hit_nxt, boot_seen_r;
  logic [15:0] rvec_nxt;

  // rank of a level: group rank times three plus place in group
  function automatic logic [3:0] lvl_rank(input logic [7:0] p, input logic [2:0] l);
    logic [1:0] g, pos, gr, ord;
    g = (l < 3'h2) ? 2'h0 : (l < 3'h5) ? 2'h1 : 2'h2;
    pos = (g == 2'h0) ? l[1:0] : (g == 2'h1) ? 2'(l - 3'h2) : 2'(l - 3'h5);
    if (p[g]) begin
      pos = (g == 2'h0) ? 2'h1 - pos : 2'h2 - pos;
    end
    ord = p[vil_pkg::PRIO_ORD_LO +: 2];
    case (ord)
      2'h1: gr = (g == 2'h0) ? 2'h2 : 2'(g - 2'h1);
      2'h2: gr = (g == 2'h2) ? 2'h0 : 2'(g + 2'h1);
      2'h3: gr = (g == 2'h0) ? 2'h0 : (g == 2'h1) ? 2'h2 : 2'h1;
      default: gr = g;
    endcase
    // widen before the product so group two does not wrap into group zero
    lvl_rank = ({2'h0, gr} * 4'h3) + {2'h0, pos};
  endfunction : lvl_rank

  // level pending is the or of its sources; active needs mask and enable
  always_comb begin
    lvl_pend = 8'h00;
    for (int s = 0; s < vil_pkg::NSRC; s++) begin
      if (src_pend_r[s]) begin
        lvl_pend[vil_pkg::SRC_LVL[s]] = 1'b1; // RULE_19 RULE_23
      end
    end
    lvl_act = lvl_pend & level_mask_reg & {8{system_mode_reg[vil_pkg::SYM_GIE]}}; // RULE_23 RULE_17
  end

  // pick the best level by rank, then the lowest source index in it
  always_comb begin
    logic [3:0] best;
    best = 4'hf;
    any_act = 1'b0;
    win_lvl = 3'h0;
    for (int l = 0; l < vil_pkg::NLVL; l++) begin
      if (lvl_act[l] && lvl_rank(level_priority_reg, 3'(l)) < best) begin // RULE_15 RULE_18
        best = lvl_rank(level_priority_reg, 3'(l));
        win_lvl = 3'(l);
        any_act = 1'b1;
      end
    end
    // index order within a level follows vector order, so low index wins
    win_src = 5'h00;
    any_src = 1'b0;
    for (int s = vil_pkg::NSRC - 1; s >= 0; s--) begin
      if (src_pend_r[s] && vil_pkg::SRC_LVL[s] == win_lvl) begin // RULE_11 RULE_12
        win_src = 5'(s);
        any_src = 1'b1;
      end
    end
  end

  // request handshake with the core; the core pushes pc and flags itself
  always_comb begin
    st_nxt = st_r;
    req_nxt = int_req_r;
    lvl_nxt = req_level_r;
    vec_nxt = vec_addr_r;
    vecn_nxt = vec_next_r;
    grant_clr = 23'h000000;
    case (st_r)
      vil_pkg::VIL_IDLE: begin
        if (any_act && any_src) begin
          st_nxt = vil_pkg::VIL_REQ;
          req_nxt = 1'b1;
          lvl_nxt = win_lvl;
          vec_nxt = vil_pkg::SRC_VEC[win_src]; // RULE_03 RULE_04 RULE_05 RULE_06
          vecn_nxt = vil_pkg::SRC_VEC[win_src] + 8'h01; // RULE_21
        end
      end
      default: begin
        if (int_ack) begin
          st_nxt = vil_pkg::VIL_IDLE;
          req_nxt = 1'b0;
          for (int s = 0; s < vil_pkg::NSRC; s++) begin
            if (vil_pkg::SRC_VEC[s] == vec_addr_r) begin
              grant_clr[s] = vil_pkg::SRC_HW_CLR[s]; // RULE_04
            end
          end
        end else if (!(any_act && any_src)) begin
          // withdraw when disabled, masked or cleared before the ack
          st_nxt = vil_pkg::VIL_IDLE;
          req_nxt = 1'b0;
        end else begin
          lvl_nxt = win_lvl;
          vec_nxt = vil_pkg::SRC_VEC[win_src]; // RULE_07 RULE_08 RULE_09 RULE_10
          vecn_nxt = vil_pkg::SRC_VEC[win_src] + 8'h01;
        end
      end
    endcase
  end

  // pending flags: a new event wins over any clear in the same cycle
  always_comb begin
    pend_nxt = (src_pend_r & ~(sw_clr_pend & ~vil_pkg::SRC_HW_CLR) & ~grant_clr) | src_evt;
  end

  // control registers; disable and grant win over enable
  always_comb begin
    mask_nxt = mask_wr ? mask_wdata : level_mask_reg; // RULE_17
    prio_nxt = prio_wr ? prio_wdata : level_priority_reg; // RULE_18
    sym_nxt = sym_wr ? (sym_wdata & vil_pkg::SYM_WMASK) : system_mode_reg; // RULE_20
    if (global_enable_instr) begin
      sym_nxt[vil_pkg::SYM_GIE] = 1'b1; // RULE_14
    end
    if (global_disable_instr || (st_r == vil_pkg::VIL_REQ && int_ack)) begin
      sym_nxt[vil_pkg::SYM_GIE] = 1'b0; // RULE_14 RULE_21
    end
  end

  // reset entry, caught once after release; write guard for vector bytes
  always_comb begin
    case (boot_sel)
      3'h1: rvec_nxt = vil_pkg::RST_VEC_ALT1;
      3'h2: rvec_nxt = vil_pkg::RST_VEC_ALT2;
      3'h3: rvec_nxt = vil_pkg::RST_VEC_ALT3;
      3'h4: rvec_nxt = vil_pkg::RST_VEC_ALT4;
      default: rvec_nxt = vil_pkg::RST_VEC_DEF; // RULE_02
    endcase
    if (boot_seen_r) begin
      rvec_nxt = reset_vec_r;
    end
    hit_nxt = 1'b0;
    if (prog_wr && prog_wr_addr[15:8] == 8'h00) begin // RULE_01
      for (int s = 0; s < vil_pkg::NSRC; s++) begin
        if (prog_wr_addr[7:0] == vil_pkg::SRC_VEC[s]
            || prog_wr_addr[7:0] == vil_pkg::SRC_VEC[s] + 8'h01) begin
          hit_nxt = 1'b1; // RULE_13
        end
      end
    end
  end

  // state registers, frozen while ce is low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= vil_pkg::VIL_IDLE;
      int_req_r <= 1'b0;
      req_level_r <= 3'h0;
      vec_addr_r <= vil_pkg::VEC_AREA_TOP;
      vec_next_r <= vil_pkg::VEC_AREA_TOP;
      src_pend_r <= vil_pkg::PEND_RST;
      level_pend_r <= 8'h00;
      level_mask_reg <= vil_pkg::MASK_RST;
      level_priority_reg <= vil_pkg::PRIO_RST;
      system_mode_reg <= vil_pkg::SYM_RST; // RULE_22
      reset_vec_r <= vil_pkg::RST_VEC_DEF;
      boot_seen_r <= 1'b0;
      vec_hit_r <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      int_req_r <= req_nxt;
      req_level_r <= lvl_nxt;
      vec_addr_r <= vec_nxt;
      vec_next_r <= vecn_nxt;
      src_pend_r <= pend_nxt;
      level_pend_r <= lvl_pend;
      level_mask_reg <= mask_nxt;
      level_priority_reg <= prio_nxt;
      system_mode_reg <= sym_nxt;
      reset_vec_r <= rvec_nxt;
      boot_seen_r <= 1'b1;
      vec_hit_r <= hit_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_grant;
    ce && int_req_r && int_ack;
  endsequence
  sequence s_off;
    !system_mode_reg[vil_pkg::SYM_GIE] && !int_req_r;
  endsequence

  a_grant_di: assert property (s_grant |=> s_off) // RULE_21
    else $error("grant did not disable interrupts");
  a_vec_pair: assert property (int_req_r |-> vec_next_r == vec_addr_r + 8'h01) // RULE_21
    else $error("second vector byte not next address");
  a_req_gate: assert property (ce && !int_req_r ##1 int_req_r
      |-> $past(system_mode_reg[vil_pkg::SYM_GIE]) && level_mask_reg[req_level_r]) // RULE_23
    else $error("request raised while disabled or masked");
  a_set_wins: assert property (ce && src_evt[1] && sw_clr_pend[1] |=> src_pend_r[1]) // RULE_03
    else $error("event lost against software clear");
  a_hw_clear: assert property (ce && int_req_r && int_ack && vec_addr_r == 8'hf4 && !src_evt[2]
      |=> !src_pend_r[2]) // RULE_04
    else $error("timer 1 overflow pending not auto-cleared");
  a_sw_only: assert property (ce && sw_clr_pend[0] && src_pend_r[0] && !src_evt[0]
      && !int_ack |=> src_pend_r[0]) // RULE_03
    else $error("software cleared a hardware-cleared flag");
  a_ei_set: assert property (ce && global_enable_instr && !global_disable_instr && !int_ack
      |=> system_mode_reg[vil_pkg::SYM_GIE]) // RULE_14
    else $error("enable instruction did not set bit 0");
  a_lvl_pend: assert property (ce ##1 1'b1 |-> level_pend_r[7] == $past(|src_pend_r[22:19])) // RULE_19
    else $error("level 7 pending not or of its sources");
  a_sym_rsv: assert property (system_mode_reg[6:5] == 2'h0) // RULE_20
    else $error("reserved mode bits set");
  a_vec_lvl7: assert property (int_req_r && req_level_r == 3'h7 |-> vec_addr_r == 8'he8) // RULE_07
    else $error("level 7 vector not shared address");
  a_lvl6_low: assert property (int_req_r && req_level_r == 3'h6 && src_pend_r[15]
      |-> vec_addr_r == 8'he0) // RULE_12
    else $error("lowest vector did not win in level 6");
endmodule : vil_ctrl

//--- design/vil_pkg.sv
package vil_pkg;
  localparam int NSRC = 23;
  localparam int NLVL = 8;
  // vector byte per source, source 0 in the low byte
  localparam logic [22:0][7:0] SRC_VEC = {
    8'he8, 8'he8, 8'he8, 8'he8, 8'he6, 8'he4, 8'he2, 8'he0,
    8'hd8, 8'hd8, 8'hd8, 8'hd8, 8'hd6, 8'hd4, 8'hd2, 8'hd0,
    8'hf2, 8'hf0, 8'hec, 8'hf6, 8'hf4, 8'hfc, 8'hfa};
  // request level per source
  localparam logic [22:0][2:0] SRC_LVL = {
    3'h7, 3'h7, 3'h7, 3'h7, 3'h6, 3'h6, 3'h6, 3'h6,
    3'h5, 3'h5, 3'h5, 3'h5, 3'h4, 3'h4, 3'h4, 3'h4,
    3'h3, 3'h3, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0};
  // sources whose pending flag hardware clears on grant
  localparam logic [22:0] SRC_HW_CLR = 23'h000035;
  localparam logic [15:0] RST_VEC_DEF = 16'h0100;
  localparam logic [15:0] RST_VEC_ALT1 = 16'h0200;
  localparam logic [15:0] RST_VEC_ALT2 = 16'h0300;
  localparam logic [15:0] RST_VEC_ALT3 = 16'h0500;
  localparam logic [15:0] RST_VEC_ALT4 = 16'h0900;
  localparam logic [7:0] VEC_AREA_TOP = 8'hff;
  localparam int SYM_GIE = 0;
  localparam int SYM_EXT_TRI = 7;
  localparam logic [7:0] SYM_WMASK = 8'h9f;
  localparam logic [7:0] SYM_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] PRIO_RST = 8'h00;
  localparam int PRIO_ORD_LO = 6;
  localparam logic [22:0] PEND_RST = 23'h000000;
  typedef enum logic {VIL_IDLE, VIL_REQ} vil_st_e;
endpackage : vil_pkg

//--- verif/vil_core_model.sv
`timescale 1ns/1ns
// core side: takes a standing request after a chosen delay and fetches two vector bytes
module vil_core_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic int_req_r,
  input wire logic [7:0] vec_addr_r,
  input wire logic [7:0] vec_next_r,
  input wire logic [3:0] ack_delay,
  output logic int_ack,
  output logic [15:0] start_addr,
  output int grants
);
  // a slow core leaves the request waiting, so the vector must stand meanwhile
  initial begin
    int_ack = 1'b0;
    start_addr = 16'h0000;
    grants = 0;
    forever begin
      @(posedge clk);
      #1;
      if (resetn === 1'b1 && int_req_r === 1'b1) begin
        repeat (ack_delay) @(posedge clk);
        #1;
        if (int_req_r === 1'b1) begin
          start_addr = {vec_addr_r, vec_next_r};
          int_ack = 1'b1;
          @(posedge clk);
          #1 int_ack = 1'b0;
          grants = grants + 1;
        end
      end
    end
  end
endmodule : vil_core_model

//--- verif/test_vectored_interrupt_levels.sv
`timescale 1ns/1ns
module test_vectored_interrupt_levels;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [22:0] evt = '0;
  logic [22:0] clr = '0;
  logic ge = 1'b0;
  logic gd = 1'b0;
  logic sym_wr = 1'b0;
  logic [7:0] sym_wdata = 8'h00;
  logic mask_wr = 1'b0;
  logic [7:0] mask_wdata = 8'h00;
  logic prog_wr = 1'b0;
  logic [15:0] prog_wr_addr = 16'h0000;
  logic [3:0] dly = 4'h0;
  logic int_ack, int_req_r, vec_hit_r;
  logic [15:0] reset_vec_r, start_addr;
  logic [2:0] req_level_r;
  logic [7:0] vec_addr_r, vec_next_r, level_pend_r, level_mask_reg, prio_r, system_mode_reg;
  logic [22:0] src_pend_r;
  int grants;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  // expected vector and level per source index, plus the hardware-cleared set
  logic [7:0] vt [23] = '{8'hfa, 8'hfc, 8'hf4, 8'hf6, 8'hec, 8'hf0, 8'hf2, 8'hd0, 8'hd2,
    8'hd4, 8'hd6, 8'hd8, 8'hd8, 8'hd8, 8'hd8, 8'he0, 8'he2, 8'he4, 8'he6, 8'he8, 8'he8,
    8'he8, 8'he8};
  logic [2:0] lv [23] = '{0, 0, 1, 1, 2, 3, 3, 4, 4, 4, 4, 5, 5, 5, 5, 6, 6, 6, 6, 7, 7, 7, 7};
  localparam logic [22:0] HWC = 23'h000035;

  vil_ctrl vil_ctrl_i (.clk(clk), .resetn(resetn), .ce(1'b1), .boot_sel(3'h3),
    .src_evt(evt), .sw_clr_pend(clr), .global_enable_instr(ge), .global_disable_instr(gd),
    .sym_wr(sym_wr), .sym_wdata(sym_wdata), .mask_wr(mask_wr), .mask_wdata(mask_wdata),
    .prio_wr(1'b0), .prio_wdata(8'h00), .int_ack(int_ack), .prog_wr(prog_wr),
    .prog_wr_addr(prog_wr_addr), .reset_vec_r(reset_vec_r), .int_req_r(int_req_r),
    .req_level_r(req_level_r), .vec_addr_r(vec_addr_r), .vec_next_r(vec_next_r),
    .src_pend_r(src_pend_r), .level_pend_r(level_pend_r), .level_mask_reg(level_mask_reg),
    .level_priority_reg(prio_r), .system_mode_reg(system_mode_reg), .vec_hit_r(vec_hit_r));
  vil_core_model vil_core_model_i (.clk(clk), .resetn(resetn), .int_req_r(int_req_r),
    .vec_addr_r(vec_addr_r), .vec_next_r(vec_next_r), .ack_delay(dly), .int_ack(int_ack),
    .start_addr(start_addr), .grants(grants));

  always #5 clk = ~clk;
  // a hang ends the run as a failure rather than stalling it
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      results();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wait_grant(input int g);
    int n;
    n = 0;
    while (grants < g && n < 60) begin
      tick(1);
      n++;
    end
    chk("grants", 16'(g), 16'(grants));
  endtask : wait_grant

  task automatic every_source();
    int g;
    for (int i = 0; i < 23; i++) begin
      dly = (i % 2) ? 4'h5 : 4'h0;
      g = grants + 1;
      evt[i] = 1'b1;
      ge = 1'b1;
      tick(1);
      evt = '0;
      ge = 1'b0;
      tick(1);
      chk("int_req_r", 16'h1, {15'h0, int_req_r});
      chk("req_level_r", 16'(lv[i]), 16'(req_level_r));
      chk("level_pend_r", 16'h1, {15'h0, level_pend_r[lv[i]]});
      chk("vec_addr_r", 16'(vt[i]), 16'(vec_addr_r));
      wait_grant(g);
      tick(1);
      chk("start_addr", {vt[i], vt[i] + 8'h01}, start_addr);
      chk("src_pend_r", {15'h0, !HWC[i]}, {15'h0, src_pend_r[i]});
      chk("mode bit 0", 16'h0, {15'h0, system_mode_reg[0]});
      clr[i] = 1'b1;
      tick(1);
      clr = '0;
      tick(2);
    end
  endtask : every_source

  task automatic prio_within(input logic [22:0] srcs);
    int g;
    evt = srcs;
    tick(1);
    evt = '0;
    for (int k = 0; k < 23; k++) begin
      if (srcs[k]) begin
        g = grants + 1;
        ge = 1'b1;
        tick(1);
        ge = 1'b0;
        wait_grant(g);
        chk("winner", 16'(vt[k]), 16'(start_addr[15:8]));
        clr[k] = 1'b1;
        tick(1);
        clr = '0;
        tick(1);
      end
    end
  endtask : prio_within

  task automatic gating();
    evt[15] = 1'b1;
    mask_wr = 1'b1;
    mask_wdata = 8'hbf;
    tick(1);
    evt = '0;
    mask_wr = 1'b0;
    sym_wr = 1'b1;
    sym_wdata = 8'h61;
    tick(1);
    sym_wr = 1'b0;
    tick(4);
    chk("system_mode_reg", 16'h0001, 16'(system_mode_reg));
    chk("level_mask_reg", 16'h00bf, 16'(level_mask_reg));
    chk("level_pend_r", 16'h0040, 16'(level_pend_r));
    chk("int_req_r masked", 16'h0, {15'h0, int_req_r});
    gd = 1'b1;
    mask_wr = 1'b1;
    mask_wdata = 8'hff;
    tick(1);
    gd = 1'b0;
    mask_wr = 1'b0;
    tick(4);
    chk("mode bit 0", 16'h0, {15'h0, system_mode_reg[0]});
    chk("int_req_r disabled", 16'h0, {15'h0, int_req_r});
    ge = 1'b1;
    tick(1);
    ge = 1'b0;
    chk("mode bit 0", 16'h1, {15'h0, system_mode_reg[0]});
    wait_grant(grants + 1);
    chk("start_addr", 16'he0e1, start_addr);
    clr[15] = 1'b1;
    tick(1);
    clr = '0;
  endtask : gating

  task automatic guard(input logic [15:0] a, input logic hit);
    prog_wr = 1'b1;
    prog_wr_addr = a;
    tick(1);
    prog_wr = 1'b0;
    chk("vec_hit_r", {15'h0, hit}, {15'h0, vec_hit_r});
    tick(1);
  endtask : guard

  task automatic results();
    if (err_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  initial begin
    #20;
    chk("reset_vec_r", 16'h0100, reset_vec_r);
    chk("system_mode_reg", 16'h0000, 16'(system_mode_reg));
    repeat (8) @(posedge clk);
    #1 resetn = 1'b1;
    tick(2);
    chk("reset_vec_r", 16'h0500, reset_vec_r);
    gating();
    every_source();
    prio_within(23'h078000);
    prio_within(23'h000003);
    guard(16'h00fd, 1'b1);
    guard(16'h00fe, 1'b0);
    guard(16'h01e8, 1'b0);
    results();
  end
endmodule : test_vectored_interrupt_levels
